// ==== core/adcc_ctrl.sv ====
// Purpose: control, timing and result capture of the converter / comparator
// Assumes: register writes arrive as one-cycle strobes from the cpu clock domain
// Notes:   the analog comparator output is asynchronous and is synchronised here
`timescale 1ns/1ps
module adcc_ctrl (
  input  wire logic                   i_clk_sys,
  input  wire logic                   i_reset,
  input  wire logic                   i_ctrl_wr,
  input  wire adcc_pkg::adcc_ctrl_s   i_ctrl_wdata,
  input  wire logic                   i_mode_wr,
  input  wire adcc_pkg::adcc_mode_s   i_mode_wdata,
  input  wire logic                   i_rlow_wr,
  input  wire adcc_pkg::adcc_rlow_s   i_rlow_wdata,
  input  wire logic                   i_rhigh_wr,
  input  wire logic [7:0]             i_rhigh_wdata,
  input  wire logic                   i_analog_above,
  output adcc_pkg::adcc_ctrl_s        o_ctrl_reg,
  output adcc_pkg::adcc_mode_s        o_mode_reg,
  output adcc_pkg::adcc_rlow_s        o_rlow_reg,
  output logic [7:0]                  o_rhigh_reg,
  output logic                        o_irq,
  output logic                        o_converting,
  output logic [3:0]                  o_sample_channel,
  output logic                        o_offset_comp,
  output logic [11:0]                 o_trial_code
);

  adcc_pkg::adcc_state_e state;
  logic [7:0]            cnt;
  logic                  above_meta;
  logic                  above_s;
  logic                  first12;
  logic                  op_cmp;
  logic                  op_resolution_select;
  logic                  start_go;
  logic                  abort;
  logic                  done;
  logic [2:0]            div_sel;
  logic [7:0]            next_len;
  logic [7:0]            run_len;
  logic [7:0]            op_len;

  assign div_sel  = {o_rlow_reg.tdiv_hi, o_mode_reg.tdiv_lo};
  // the compare bit of the start write itself applies, so software may set compare and start together
  assign next_len = adcc_pkg::adcc_op_cycles(i_ctrl_wdata.cmp, o_mode_reg.resolution_select, div_sel, first12);
  assign abort    = i_ctrl_wr && !i_ctrl_wdata.start && (state == adcc_pkg::ADCC_ST_RUN);
  assign done     = (state == adcc_pkg::ADCC_ST_RUN) && (cnt == 8'h01) && !abort;
  // a write of start while already running does not restart the operation
  assign start_go = i_ctrl_wr && i_ctrl_wdata.start && (state == adcc_pkg::ADCC_ST_IDLE || done);

  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      above_meta <= 1'b0;
      above_s    <= 1'b0;
    end else begin
      above_meta <= i_analog_above;
      above_s    <= above_meta;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // state and cycle counter; reset drops any operation at once
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      state <= adcc_pkg::ADCC_ST_IDLE;
      cnt   <= 8'h00;
    end else if (start_go) begin
      state <= adcc_pkg::ADCC_ST_RUN;
      cnt   <= next_len;
    end else if (abort || done) begin
      state <= adcc_pkg::ADCC_ST_IDLE;
      cnt   <= 8'h00;
    end else if (state == adcc_pkg::ADCC_ST_RUN) begin
      cnt <= cnt - 8'h01;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      op_cmp           <= 1'b0;
      op_resolution_select         <= 1'b0;
      op_len           <= 8'h00;
      o_sample_channel <= 4'h0;
    end else if (start_go) begin
      op_cmp           <= i_ctrl_wdata.cmp;
      op_resolution_select         <= o_mode_reg.resolution_select;
      op_len           <= next_len;
      o_sample_channel <= i_ctrl_wdata.channel;
    end
  end

  // first twelve-bit conversion after reset or after leaving eight-bit mode runs twice as long
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      first12 <= 1'b1;
    end else if (i_mode_wr && o_mode_reg.resolution_select && !i_mode_wdata.resolution_select) begin
      first12 <= 1'b1;
    end else if (start_go && !i_ctrl_wdata.cmp && !o_mode_reg.resolution_select) begin
      first12 <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      o_ctrl_reg <= adcc_pkg::adcc_ctrl_s'(adcc_pkg::ADCC_RST_BYTE);
    end else begin
      if (i_ctrl_wr) begin
        o_ctrl_reg <= i_ctrl_wdata;
      end
      // completion beats a same-cycle software clear of the flag
      if (done) begin
        o_ctrl_reg.flag <= 1'b1;
        if (!start_go) begin
          o_ctrl_reg.start <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      o_mode_reg <= adcc_pkg::adcc_mode_s'(adcc_pkg::ADCC_RST_BYTE);
    end else if (i_mode_wr) begin
      o_mode_reg           <= i_mode_wdata;
      o_mode_reg.fixed_hi  <= 1'b0;
      o_mode_reg.fixed_mid <= 3'h0;
    end
  end

  // result bytes double as plain storage; a completion that stores into a byte overrides a same-cycle write to it
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      o_rlow_reg <= adcc_pkg::adcc_rlow_s'(adcc_pkg::ADCC_RST_BYTE);
    end else if (done && op_cmp) begin
      o_rlow_reg.data[3] <= above_s;
    end else if (done && !op_resolution_select) begin
      o_rlow_reg.data <= o_trial_code[3:0];
    end else if (i_rlow_wr) begin
      o_rlow_reg           <= i_rlow_wdata;
      o_rlow_reg.fixed_mid <= 3'h0;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      o_rhigh_reg <= adcc_pkg::ADCC_RST_BYTE;
    end else if (done && !op_cmp) begin
      o_rhigh_reg <= o_trial_code[11:4];
    end else if (i_rhigh_wr) begin
      o_rhigh_reg <= i_rhigh_wdata;
    end
  end

  assign o_irq         = o_ctrl_reg.flag && o_ctrl_reg.irq_en;
  assign o_converting  = (state == adcc_pkg::ADCC_ST_RUN);
  assign o_offset_comp = o_mode_reg.offs;

  //////////////////////////////////////////////////////////////////////////////
  // comparator mode holds the reference as a fixed trial level instead of walking bits
  adcc_sar_step #(
    .RES_W (adcc_pkg::ADCC_RES_W)
  ) i_adcc_sar_step (
    .i_clk_sys  (i_clk_sys),
    .i_reset    (i_reset),
    .i_load     (start_go),
    .i_stop     (abort),
    .i_hold     (i_ctrl_wdata.cmp),
    .i_seed     (i_ctrl_wdata.cmp ? {o_rhigh_reg, 4'h0} : adcc_pkg::ADCC_SAR_SEED),
    .i_last_bit (o_mode_reg.resolution_select ? adcc_pkg::ADCC_LAST_8 : adcc_pkg::ADCC_LAST_12),
    .i_above    (above_s),
    .o_trial    (o_trial_code)
  );

  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge i_clk_sys) begin
    if (i_reset || start_go) begin
      run_len <= 8'h00;
    end else if (state == adcc_pkg::ADCC_ST_RUN) begin
      run_len <= run_len + 8'h01;
    end
  end

  a_start_begins: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    start_go |=> o_converting && o_ctrl_reg.start)
    else $error("start write did not begin an operation");

  a_done_flag_start: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    done && !start_go |=> o_ctrl_reg.flag && !o_ctrl_reg.start && !o_converting)
    else $error("completion did not set flag and clear start");

  a_flag_held: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    o_ctrl_reg.flag && !(i_ctrl_wr && !i_ctrl_wdata.flag) |=> o_ctrl_reg.flag)
    else $error("completion flag dropped without software clear");

  a_irq_on_flag: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    done && o_ctrl_reg.irq_en && !i_ctrl_wr |=> o_irq)
    else $error("enabled completion raised no interrupt");

  a_run_length: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    done |-> (run_len + 8'h01) == op_len)
    else $error("operation length differs from programmed time");

  a_cmp_result: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    done && op_cmp && !i_rhigh_wr |=> o_rlow_reg.data[3] == $past(above_s) && o_rhigh_reg == $past(o_rhigh_reg))
    else $error("comparison outcome not stored or reference lost");

  a_conv12_store: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    done && !op_cmp && !op_resolution_select |=> {o_rhigh_reg, o_rlow_reg.data} == $past(o_trial_code))
    else $error("twelve-bit result stored wrongly");

  a_abort_stops: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    abort |=> !o_converting && !$rose(o_ctrl_reg.flag))
    else $error("abort did not stop the operation");

  a_reset_halts: assert property (@(posedge i_clk_sys)
    i_reset |=> !o_converting && !o_ctrl_reg.start && !o_ctrl_reg.flag)
    else $error("reset did not halt the converter");

  a_channel_taken: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    start_go |=> o_sample_channel == $past(i_ctrl_wdata.channel))
    else $error("sampled channel differs from channel field");

endmodule : adcc_ctrl

// ==== core/adcc_pkg.sv ====
// Purpose: shared constants, register layouts and helpers of the converter control block
// Assumes: one cycle clock, synchronous active-high reset
// Notes:   register images travel as packed 8-bit structs
// Operation
// - resolution bit 0 selects twelve-bit conversion
// - time bits pick division ratio, 1/01 is 1/32
// - control bits 7..4 choose the input channel
// - writing start bit 1 begins an operation
// - completion sets flag and clears start together
// - enabled flag raises the completion interrupt
// - compare bit selects comparator mode, needs offset
// - comparison lasts 28 over ratio plus two
// - low byte bit 7 gives comparison outcome
// - writing start 0 mid-operation aborts it
// - reset clears start and halts at once
// - twelve-bit result splits high byte, low nibble
// - conversion lasts 52 over ratio plus two, doubled first
package adcc_pkg;

  typedef struct packed {
    logic [3:0] channel;
    logic       cmp;
    logic       start;
    logic       flag;
    logic       irq_en;
  } adcc_ctrl_s;

  typedef struct packed {
    logic       fixed_hi;
    logic       resolution_select;
    logic [2:0] fixed_mid;
    logic       offs;
    logic [1:0] tdiv_lo;
  } adcc_mode_s;

  typedef struct packed {
    logic [3:0] data;
    logic [2:0] fixed_mid;
    logic       tdiv_hi;
  } adcc_rlow_s;

  typedef enum logic {
    ADCC_ST_IDLE,
    ADCC_ST_RUN
  } adcc_state_e;

  localparam int         ADCC_RES_W    = 12;
  localparam int         ADCC_CNT_W    = 8;
  localparam int         ADCC_STEP_CYC = 3;
  localparam logic [7:0] ADCC_BASE_12  = 8'h34;
  localparam logic [7:0] ADCC_BASE_8   = 8'h20;
  localparam logic [7:0] ADCC_BASE_CMP = 8'h1C;
  localparam logic [7:0] ADCC_EXTRA    = 8'h02;
  localparam logic [7:0] ADCC_RST_BYTE = 8'h00;
  localparam logic [3:0] ADCC_LAST_12  = 4'h0;
  localparam logic [3:0] ADCC_LAST_8   = 4'h4;
  localparam logic [11:0] ADCC_SAR_SEED = 12'h800;

  // operation length in cycle-clock periods; the ratio is a power of two so a shift divides, dropping any remainder
  function automatic logic [7:0] adcc_op_cycles(input logic is_cmp, input logic resolution_select,
                                                input logic [2:0] sel, input logic dbl);
    logic [7:0] base;
    logic [7:0] len;
    base = is_cmp ? ADCC_BASE_CMP : (resolution_select ? ADCC_BASE_8 : ADCC_BASE_12);
    len  = (base >> sel) + ADCC_EXTRA;
    adcc_op_cycles = (dbl && !is_cmp && !resolution_select) ? {len[6:0], 1'b0} : len;
  endfunction : adcc_op_cycles

endpackage : adcc_pkg

// ==== core/adcc_sar_step.sv ====
// Purpose: successive-approximation trial register driving the analog trial code
// Assumes: i_above is already synchronised; one decision every step period
// Notes:   a short conversion time captures the code mid-walk; the walk runs on, with the bit under trial at 1 and lower bits at 0
`timescale 1ns/1ps
module adcc_sar_step #(
  parameter int RES_W = adcc_pkg::ADCC_RES_W
) (
  input  wire logic             i_clk_sys,
  input  wire logic             i_reset,
  input  wire logic             i_load,
  input  wire logic             i_stop,
  input  wire logic             i_hold,
  input  wire logic [RES_W-1:0] i_seed,
  input  wire logic [3:0]       i_last_bit,
  input  wire logic             i_above,
  output logic      [RES_W-1:0] o_trial
);

  logic       active;
  logic [3:0] bit_pos;
  logic [1:0] step;

  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge i_clk_sys) begin
    if (i_reset || i_stop) begin
      o_trial <= '0;
      active  <= 1'b0;
      bit_pos <= 4'h0;
      step    <= 2'h0;
    end else if (i_load) begin
      o_trial <= i_seed;
      bit_pos <= 4'(RES_W - 1);
      step    <= 2'h0;
      active  <= !i_hold;
    end else if (active) begin
      if (step == 2'(adcc_pkg::ADCC_STEP_CYC - 1)) begin
        step <= 2'h0;
        // drop the trial bit when the input sits below the trial level
        if (!i_above) begin
          o_trial[bit_pos] <= 1'b0;
        end
        if (bit_pos == i_last_bit) begin
          active <= 1'b0;
        end else begin
          bit_pos              <= bit_pos - 4'h1;
          o_trial[bit_pos-4'h1] <= 1'b1;
        end
      end else begin
        step <= step + 2'h1;
      end
    end
  end

endmodule : adcc_sar_step

// ==== tb/adcc_ctrl_tb.sv ====
// Purpose: self-checking bench of the converter control block
// Assumes: strobes are driven 2 ns after the rising edge and last one cycle
// Notes:   a monitor checks every end of operation against the oldest queued note
`timescale 1ns/1ps
module adcc_ctrl_tb;
  typedef struct packed {
    logic [7:0] len;
    logic       flag;
    logic [7:0] mask;
    logic [7:0] val;
  } adcc_note_s;

  logic                 i_clk_sys      = 1'h0;
  logic                 i_reset        = 1'h1;
  logic                 i_ctrl_wr      = 1'h0;
  adcc_pkg::adcc_ctrl_s i_ctrl_wdata   = '0;
  logic                 i_mode_wr      = 1'h0;
  adcc_pkg::adcc_mode_s i_mode_wdata   = '0;
  logic                 i_rlow_wr      = 1'h0;
  adcc_pkg::adcc_rlow_s i_rlow_wdata   = '0;
  logic                 i_rhigh_wr     = 1'h0;
  logic [7:0]           i_rhigh_wdata  = 8'h00;
  logic                 i_analog_above = 1'h0;
  adcc_pkg::adcc_ctrl_s o_ctrl_reg;
  adcc_pkg::adcc_mode_s o_mode_reg;
  adcc_pkg::adcc_rlow_s o_rlow_reg;
  logic [7:0]           o_rhigh_reg;
  logic                 o_irq;
  logic                 o_converting;
  logic [3:0]           o_sample_channel;
  logic                 o_offset_comp;
  logic [11:0]          o_trial_code;
  int                   n_fail         = 0;
  int                   comparisons    = 0;
  int                   cnt            = 0;
  int                   s;
  logic [31:0]          seed           = 32'h0000FC73;
  logic                 use_vin        = 1'h0;
  logic                 above_bit      = 1'h0;
  logic                 was_conv       = 1'h0;
  logic [11:0]          vin            = 12'h000;
  adcc_note_s           nt;
  adcc_note_s           notes[$];

  adcc_ctrl i_adcc_ctrl (
    .i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_ctrl_wr(i_ctrl_wr), .i_ctrl_wdata(i_ctrl_wdata),
    .i_mode_wr(i_mode_wr), .i_mode_wdata(i_mode_wdata), .i_rlow_wr(i_rlow_wr), .i_rlow_wdata(i_rlow_wdata),
    .i_rhigh_wr(i_rhigh_wr), .i_rhigh_wdata(i_rhigh_wdata), .i_analog_above(i_analog_above),
    .o_ctrl_reg(o_ctrl_reg), .o_mode_reg(o_mode_reg), .o_rlow_reg(o_rlow_reg), .o_rhigh_reg(o_rhigh_reg),
    .o_irq(o_irq), .o_converting(o_converting), .o_sample_channel(o_sample_channel),
    .o_offset_comp(o_offset_comp), .o_trial_code(o_trial_code)
  );

  always #12.5 i_clk_sys = ~i_clk_sys;
  // converter runs see a level that answers the trial code; comparisons see a fixed level
  // equal counts as above, so a full walk ends on vin itself
  always @(posedge i_clk_sys) #2 i_analog_above = use_vin ? (vin >= o_trial_code) : above_bit;

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xorshift(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    xorshift = x ^ (x << 5);
  endfunction : xorshift

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  task automatic final_report();
    $display("comparisons %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : final_report

  // kind 0 control, 1 mode, 2 result low, 3 result high
  task automatic wr(input int kind, input logic [7:0] d);
    @(posedge i_clk_sys) #2;
    i_ctrl_wdata  = d;
    i_mode_wdata  = d;
    i_rlow_wdata  = d;
    i_rhigh_wdata = d;
    i_ctrl_wr     = (kind == 0);
    i_mode_wr     = (kind == 1);
    i_rlow_wr     = (kind == 2);
    i_rhigh_wr    = (kind == 3);
    @(posedge i_clk_sys) #2;
    i_ctrl_wr     = 1'h0;
    i_mode_wr     = 1'h0;
    i_rlow_wr     = 1'h0;
    i_rhigh_wr    = 1'h0;
  endtask : wr

  task automatic run_op(input logic cmp, input logic resolution_select, input logic [2:0] sel,
                        input logic [3:0] ch, input logic [7:0] len);
    logic [7:0] rd;
    logic [7:0] ref_v;
    logic       ie;
    int         i;
    seed      = xorshift(seed);
    rd        = seed[7:0];
    ref_v     = seed[15:8];
    ie        = seed[16];
    above_bit = seed[17];
    vin       = seed[29:18];
    use_vin   = !cmp;
    wr(1, {1'h0, resolution_select, 3'h0, cmp, sel[1:0]});
    wr(2, {rd[7:4], 3'h0, sel[2]});
    wr(3, ref_v);
    notes.push_back({len, 1'h1, cmp ? 8'h80 : (resolution_select ? 8'hFF : 8'h01),
                     cmp ? {above_bit, 7'h00} : (resolution_select ? {rd[7:4], 3'h0, sel[2]} : {7'h00, sel[2]})});
    wr(0, {ch, cmp, 1'h1, 1'h0, ie});
    @(posedge i_clk_sys) #2;
    if (cmp) check(o_trial_code[11:4], ref_v);
    check(o_sample_channel, ch);
    check(o_offset_comp, cmp);
    for (i = 0; i < 300 && o_ctrl_reg.flag !== 1'h1; i++) @(posedge i_clk_sys) #2;
    repeat (3) @(posedge i_clk_sys) #2;
    check(o_ctrl_reg.flag, 1'h1);
    check(o_irq, ie);
    check(o_ctrl_reg.start, 1'h0);
    if (cmp) check(o_rhigh_reg, ref_v);
    if (!cmp && sel == 3'h0) check(o_rhigh_reg, vin[11:4]);
    if (!cmp && !resolution_select && sel == 3'h0) check(o_rlow_reg.data, vin[3:0]);
    wr(0, {ch, cmp, 2'h0, ie});
    check(o_irq, 1'h0);
  endtask : run_op

  ////////////////////////////////////////////////////////////////////////////////
  always @(negedge i_clk_sys) begin
    if (o_converting === 1'h1) begin
      cnt++;
    end else if (was_conv) begin
      if (notes.size() == 0) begin
        check(16'h0001, 16'h0000);
      end else begin
        nt = notes.pop_front();
        if (nt.len != 8'h00) check(16'(cnt), {8'h00, nt.len});
        check(o_ctrl_reg.flag, nt.flag);
        check(o_ctrl_reg.start, 1'h0);
        check(o_rlow_reg & nt.mask, nt.val);
      end
      cnt = 0;
    end
    was_conv = (o_converting === 1'h1);
  end

  initial begin
    #300000;
    n_fail++;
    final_report();
  end

  initial begin
    repeat (2) @(posedge i_clk_sys);
    #2 i_reset = 1'h0;
    check({o_ctrl_reg, o_mode_reg}, 16'h0000);
    check({o_rlow_reg, o_rhigh_reg}, 16'h0000);
    check({o_irq, o_converting}, 16'h0000);
    wr(1, 8'hB8);
    wr(2, 8'h0E);
    check({o_mode_reg, o_rlow_reg}, 16'h0000);
    for (s = 0; s < 8; s++) run_op(1'h1, 1'h0, s[2:0], 4'(s + 8), (8'h1C >> s) + 8'h02);
    run_op(1'h0, 1'h0, 3'h5, 4'h1, 8'h06);
    run_op(1'h0, 1'h0, 3'h5, 4'h1, 8'h03);
    run_op(1'h0, 1'h1, 3'h0, 4'h2, 8'h22);
    run_op(1'h0, 1'h0, 3'h7, 4'h3, 8'h04);
    run_op(1'h0, 1'h0, 3'h0, 4'h4, 8'h36);
    for (s = 0; s < 16; s++) run_op(1'h0, 1'h0, 3'h7, s[3:0], 8'h02);
    // abort mid-comparison, then a reset mid-comparison
    wr(1, 8'h04);
    wr(2, 8'h00);
    notes.push_back('0);
    wr(0, 8'h1C);
    repeat (5) @(posedge i_clk_sys) #2;
    wr(0, 8'h18);
    repeat (40) @(posedge i_clk_sys) #2;
    check(o_ctrl_reg.flag, 1'h0);
    check(o_trial_code, 12'h000);
    notes.push_back('0);
    wr(0, 8'h1C);
    repeat (5) @(posedge i_clk_sys) #2;
    i_reset = 1'h1;
    repeat (2) @(posedge i_clk_sys) #2;
    i_reset = 1'h0;
    check(o_ctrl_reg, 8'h00);
    check(o_converting, 1'h0);
    check(notes.size(), 16'h0000);
    final_report();
  end
endmodule : adcc_ctrl_tb
